// *** verilog/umd_unit.sv ***
`timescale 1ns/1ns
`include "umd_consts.svh"
// Unsigned multiply/divide unit: computes at start, then holds busy for all but the
// last of the instruction's cycles and pulses done in that last one, so the sequencer sees the real timing.
module umd_unit #(
   parameter int ACC_W = 32,
   parameter int CORR_W = 6
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [3:0] op_i,
   input wire logic [31:0] acc_i,
   input wire logic [15:0] opnd_i,
   input wire logic [CORR_W-1:0] addr_cycles_i,
   input wire logic [CORR_W-1:0] access_count_i,
   input wire logic flag_v_i,
   input wire logic flag_c_i,
   output logic busy_o,
   output logic done_o,
   output logic [31:0] acc_o,
   output logic acc_we_o,
   output logic [15:0] opnd_o,
   output logic opnd_we_o,
   output logic flag_v_o,
   output logic flag_c_o,
   output logic flags_we_o,
   output logic [7:0] cycles_o,
   output logic [7:0] accesses_o
);
   // The accumulator ports are fixed at 32 bits, and the cycle sum must fit 8 bits
   if (ACC_W != 32 || CORR_W < 1 || CORR_W > 7) begin : g_bad_params
      $error("umd_unit: unsupported parameter values");
   end

   umd_calc_if calc ();
   umd_div_core u_div (.c(calc));

   umd_pkg::umd_op_t op;
   umd_pkg::umd_state_t state;
   umd_pkg::umd_outcome_t outc;
   logic is_div;
   logic is_mem;
   logic [5:0] base_cyc;
   logic [7:0] next_cycles;
   logic [7:0] next_acc_cnt;
   logic [31:0] next_acc;
   logic [15:0] next_opnd;
   logic next_opnd_we;
   logic [7:0] remain;

   assign op = umd_pkg::umd_op_t'(op_i);

   //==========================================================================
   // Operand routing to the divider
   always_comb begin
      calc.is_word = (op == umd_pkg::UMD_QW_REG) || (op == umd_pkg::UMD_QW_MEM);
      if (op == umd_pkg::UMD_DIV_ACC) begin
         calc.dividend = {16'h0000, acc_i[31:16]}; // [RL1]
         calc.divisor = {8'h00, acc_i[7:0]};
      end else if (calc.is_word) begin
         calc.dividend = acc_i; // [RL5]
         calc.divisor = opnd_i;
      end else begin
         calc.dividend = {16'h0000, acc_i[15:0]};
         calc.divisor = {8'h00, opnd_i[7:0]};
      end
   end

   //==========================================================================
   // Result, outcome class and timing selection
   always_comb begin
      is_div = (op_i <= 4'h4);
      is_mem = (op == umd_pkg::UMD_DIV_MEM) || (op == umd_pkg::UMD_QW_MEM) ||
               (op == umd_pkg::UMD_PB_MEM) || (op == umd_pkg::UMD_PW_MEM);
      next_acc = acc_i;
      next_opnd = opnd_i;
      next_opnd_we = 1'b0;
      outc = umd_pkg::UMD_OUT_NORM;
      base_cyc = `UMD_MULB_NORM;
      if (is_div) begin
         if (calc.div_zero) begin
            outc = umd_pkg::UMD_OUT_ZERO;
         end else if (calc.div_ovf) begin
            outc = umd_pkg::UMD_OUT_OVF;
         end
      end
      unique case (op)
         umd_pkg::UMD_DIV_ACC: begin
            // Quotient to the low byte of the lower half, remainder to that of the upper
            if (outc == umd_pkg::UMD_OUT_NORM) begin
               next_acc = {acc_i[31:24], calc.rem[7:0], acc_i[15:8], calc.quot[7:0]}; // [RL1]
            end
            base_cyc = (outc == umd_pkg::UMD_OUT_ZERO) ? `UMD_DIVA_ZERO :
                       (outc == umd_pkg::UMD_OUT_OVF) ? `UMD_DIVA_OVF : `UMD_DIVA_NORM; // [RL2]
         end
         umd_pkg::UMD_DIV_REG, umd_pkg::UMD_DIV_MEM: begin
            if (outc == umd_pkg::UMD_OUT_NORM) begin
               next_acc = {acc_i[31:8], calc.quot[7:0]};
               next_opnd = {opnd_i[15:8], calc.rem[7:0]};
               next_opnd_we = 1'b1;
            end
            if (op == umd_pkg::UMD_DIV_REG) begin
               base_cyc = (outc == umd_pkg::UMD_OUT_ZERO) ? `UMD_DIVR_ZERO :
                          (outc == umd_pkg::UMD_OUT_OVF) ? `UMD_DIVR_OVF : `UMD_DIVR_NORM; // [RL3]
            end else begin
               base_cyc = (outc == umd_pkg::UMD_OUT_ZERO) ? `UMD_DIVM_ZERO :
                          (outc == umd_pkg::UMD_OUT_OVF) ? `UMD_DIVM_OVF : `UMD_DIVM_NORM; // [RL4]
            end
         end
         umd_pkg::UMD_QW_REG, umd_pkg::UMD_QW_MEM: begin
            if (outc == umd_pkg::UMD_OUT_NORM) begin
               next_acc = {acc_i[31:16], calc.quot}; // [RL5]
               next_opnd = calc.rem;
               next_opnd_we = 1'b1;
            end
            if (op == umd_pkg::UMD_QW_REG) begin
               base_cyc = (outc == umd_pkg::UMD_OUT_ZERO) ? `UMD_QWR_ZERO :
                          (outc == umd_pkg::UMD_OUT_OVF) ? `UMD_QWR_OVF : `UMD_QWR_NORM; // [RL5]
            end else begin
               base_cyc = (outc == umd_pkg::UMD_OUT_ZERO) ? `UMD_QWM_ZERO :
                          (outc == umd_pkg::UMD_OUT_OVF) ? `UMD_QWM_OVF : `UMD_QWM_NORM; // [RL6]
            end
         end
         umd_pkg::UMD_PB_ACC: begin
            // Operands widened first: a bare byte product inside braces keeps 8 bits
            next_acc = {16'h0000, {8'h00, acc_i[23:16]} * {8'h00, acc_i[7:0]}}; // [RL9]
            base_cyc = (acc_i[23:16] == 8'h00) ? `UMD_MULB_ZERO : `UMD_MULB_NORM; // [RL9]
         end
         umd_pkg::UMD_PB_REG: begin
            next_acc = {16'h0000, {8'h00, acc_i[7:0]} * {8'h00, opnd_i[7:0]}}; // [RL10]
            base_cyc = (opnd_i[7:0] == 8'h00) ? `UMD_MULB_ZERO : `UMD_MULB_NORM; // [RL10]
         end
         umd_pkg::UMD_PB_MEM: begin
            next_acc = {16'h0000, {8'h00, acc_i[7:0]} * {8'h00, opnd_i[7:0]}};
            base_cyc = (opnd_i[7:0] == 8'h00) ? `UMD_MULBM_ZERO : `UMD_MULBM_NORM; // [RL11]
         end
         umd_pkg::UMD_PW_ACC: begin
            next_acc = acc_i[31:16] * acc_i[15:0]; // [RL12]
            base_cyc = (acc_i[31:16] == 16'h0) ? `UMD_PW_ZERO : `UMD_PW_NORM; // [RL12]
         end
         umd_pkg::UMD_PW_REG: begin
            next_acc = acc_i[15:0] * opnd_i; // [RL13]
            base_cyc = (opnd_i == 16'h0) ? `UMD_PW_ZERO : `UMD_PW_NORM; // [RL13]
         end
         umd_pkg::UMD_PW_MEM: begin
            next_acc = acc_i[15:0] * opnd_i;
            base_cyc = (opnd_i == 16'h0) ? `UMD_MULWM_ZERO : `UMD_MULWM_NORM; // [RL14]
         end
         default: begin
            base_cyc = `UMD_MULB_ZERO; // Illegal code: short no-op
         end
      endcase
      // Memory forms add the fetch logic's correction figures
      next_cycles = {2'b00, base_cyc};
      next_acc_cnt = 8'h00;
      if (is_mem) begin
         next_cycles = 8'({2'b00, base_cyc} + 8'(addr_cycles_i)); // [RL16]
         next_acc_cnt = 8'(access_count_i); // [RL16]
         if (is_div && outc == umd_pkg::UMD_OUT_NORM) begin
            next_acc_cnt = 8'({8'(access_count_i), 1'b0}); // [RL7] [RL8]
         end
      end
   end

   //==========================================================================
   // Sequencer: busy for one cycle less than the count, done on the last cycle; results are latched at start
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state <= umd_pkg::UMD_IDLE;
         remain <= 8'h00;
         busy_o <= 1'b0;
      end else begin
         unique case (state)
            umd_pkg::UMD_IDLE: begin
               if (start_i) begin
                  state <= umd_pkg::UMD_BUSY;
                  remain <= 8'(next_cycles - 8'h01);
                  busy_o <= 1'b1;
               end
            end
            umd_pkg::UMD_BUSY: begin
               remain <= 8'(remain - 8'h01);
               if (remain == 8'h01) begin
                  state <= umd_pkg::UMD_IDLE;
                  busy_o <= 1'b0;
               end
            end
         endcase
      end
   end

   // Latch results at start; operands may change once busy is seen
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         acc_o <= 32'h0;
         opnd_o <= 16'h0;
         flag_v_o <= 1'b0;
         flag_c_o <= 1'b0;
         cycles_o <= 8'h00;
         accesses_o <= 8'h00;
         acc_we_o <= 1'b0;
         opnd_we_o <= 1'b0;
         flags_we_o <= 1'b0;
      end else if (state == umd_pkg::UMD_IDLE && start_i) begin
         acc_o <= next_acc;
         opnd_o <= next_opnd;
         acc_we_o <= !is_div || (outc == umd_pkg::UMD_OUT_NORM);
         opnd_we_o <= next_opnd_we;
         flags_we_o <= is_div; // [RL15]
         // Divide sets V on zero/overflow, clears C; multiply passes flags
         flag_v_o <= is_div ? (outc != umd_pkg::UMD_OUT_NORM) : flag_v_i; // [RL15]
         flag_c_o <= is_div ? 1'b0 : flag_c_i; // [RL15]
         cycles_o <= next_cycles;
         accesses_o <= next_acc_cnt;
      end
   end

   // One-cycle completion pulse when the count runs out
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         done_o <= 1'b0;
      end else begin
         done_o <= (state == umd_pkg::UMD_BUSY) && (remain == 8'h01);
      end
   end

   //==========================================================================
   // Checks
   sequence s_start_div;
      (state == umd_pkg::UMD_IDLE) && start_i && is_div;
   endsequence

   // A request counts as taken only while the unit is idle
   sequence s_taken;
      (state == umd_pkg::UMD_IDLE) && start_i;
   endsequence

   // Busy is seen high on N-1 edges; the done cycle already shows it low
   a_accdiv_zero_time: assert property (@(posedge clock_i) disable iff (rst_i) // [RL2]
      (state == umd_pkg::UMD_IDLE) && start_i && op == umd_pkg::UMD_DIV_ACC && calc.div_zero
      |=> busy_o [*2] ##1 !busy_o)
      else $error("acc divide by zero not 3 cycles");
   a_accdiv_norm_time: assert property (@(posedge clock_i) disable iff (rst_i) // [RL2]
      s_taken and (op == umd_pkg::UMD_DIV_ACC && outc == umd_pkg::UMD_OUT_NORM)
      |-> ##14 done_o)
      else $error("acc divide not 14 cycles");
   a_regdiv_cycles: assert property (@(posedge clock_i) disable iff (rst_i) // [RL3]
      s_taken and (op == umd_pkg::UMD_DIV_REG && outc == umd_pkg::UMD_OUT_OVF)
      |=> cycles_o == 8'h05)
      else $error("reg byte divide overflow count wrong");
   a_memdiv_cycles: assert property (@(posedge clock_i) disable iff (rst_i) // [RL4]
      (state == umd_pkg::UMD_IDLE) && start_i && op == umd_pkg::UMD_DIV_MEM
      |=> cycles_o >= 8'h05)
      else $error("mem byte divide count too small");
   a_wdiv_norm_time: assert property (@(posedge clock_i) disable iff (rst_i) // [RL5]
      s_taken and (op == umd_pkg::UMD_QW_REG && outc == umd_pkg::UMD_OUT_NORM)
      |-> ##21 done_o)
      else $error("reg word divide not 21 cycles");
   a_mem_access_double: assert property (@(posedge clock_i) disable iff (rst_i) // [RL7]
      s_start_div and (is_mem && outc == umd_pkg::UMD_OUT_NORM)
      |=> accesses_o == 8'($past(access_count_i)) * 8'h02)
      else $error("normal mem divide access count not doubled");
   a_pw_acc_time: assert property (@(posedge clock_i) disable iff (rst_i) // [RL12]
      s_taken and (op == umd_pkg::UMD_PW_ACC && acc_i[31:16] != 16'h0)
      |-> ##11 done_o)
      else $error("acc word multiply not 11 cycles");
   a_product_no_flags: assert property (@(posedge clock_i) disable iff (rst_i) // [RL15]
      (state == umd_pkg::UMD_IDLE) && start_i && !is_div |=> !flags_we_o)
      else $error("multiply wrote flags");

   // Further timing and count checks for some of the outcomes the scenarios reach
   a_accdiv_ovf_time: assert property (@(posedge clock_i) disable iff (rst_i) // [RL2]
      s_taken and (op == umd_pkg::UMD_DIV_ACC && outc == umd_pkg::UMD_OUT_OVF)
      |-> ##6 done_o)
      else $error("acc divide overflow not 6 cycles");
   a_regdiv_norm_time: assert property (@(posedge clock_i) disable iff (rst_i) // [RL3]
      s_taken and (op == umd_pkg::UMD_DIV_REG && outc == umd_pkg::UMD_OUT_NORM)
      |-> ##13 done_o)
      else $error("reg byte divide not 13 cycles");
   a_memwdiv_cycles: assert property (@(posedge clock_i) disable iff (rst_i) // [RL6]
      s_taken and (op == umd_pkg::UMD_QW_MEM && outc == umd_pkg::UMD_OUT_NORM)
      |=> cycles_o == 8'(`UMD_QWM_NORM) + 8'($past(addr_cycles_i)))
      else $error("mem word divide cycle count wrong");
   a_memwdiv_single: assert property (@(posedge clock_i) disable iff (rst_i) // [RL8]
      s_start_div and (op == umd_pkg::UMD_QW_MEM && outc != umd_pkg::UMD_OUT_NORM)
      |=> accesses_o == 8'($past(access_count_i)))
      else $error("cut short mem word divide access count not single");
   a_pb_acc_time: assert property (@(posedge clock_i) disable iff (rst_i) // [RL9]
      s_taken and (op == umd_pkg::UMD_PB_ACC && acc_i[23:16] != 8'h00)
      |-> ##7 done_o)
      else $error("acc byte multiply not 7 cycles");
   a_pb_reg_zero: assert property (@(posedge clock_i) disable iff (rst_i) // [RL10]
      s_taken and (op == umd_pkg::UMD_PB_REG && opnd_i[7:0] == 8'h00)
      |-> ##3 done_o)
      else $error("reg byte multiply by zero not 3 cycles");
   a_pb_mem_cycles: assert property (@(posedge clock_i) disable iff (rst_i) // [RL11]
      s_taken and (op == umd_pkg::UMD_PB_MEM && opnd_i[7:0] != 8'h00)
      |=> cycles_o == 8'(`UMD_MULBM_NORM) + 8'($past(addr_cycles_i)))
      else $error("mem byte multiply cycle count wrong");
   a_pw_reg_time: assert property (@(posedge clock_i) disable iff (rst_i) // [RL13]
      s_taken and (op == umd_pkg::UMD_PW_REG && opnd_i != 16'h0)
      |-> ##11 done_o)
      else $error("reg word multiply not 11 cycles");
endmodule

// *** verilog/umd_consts.svh ***
`ifndef UMD_CONSTS_SVH
`define UMD_CONSTS_SVH
//==========================================================================
// Summary of operation
// RL1: Accumulator byte divide: upper half over lower byte, quotient low, remainder high.
// RL2: Accumulator byte divide takes 3 cycles zero divisor, 6 overflow, 14 normal.
// RL3: Register byte divide takes 3 cycles zero divisor, 5 overflow, 13 normal.
// RL4: Memory byte divide takes 5, 7 or 17 plus addressing cycles.
// RL5: Register word divide: 32 over 16 bits; 3, 5 or 21 cycles.
// RL6: Memory word divide takes 4, 7 or 25 plus addressing cycles.
// RL7: Memory byte divide: one byte-access count on zero/overflow, two when normal.
// RL8: Memory word divide: one word-access count on zero/overflow, two when normal.
// RL9: Accumulator byte multiply upper by lower byte; 3 cycles if upper zero, else 7.
// RL10: Register byte multiply; 3 cycles if register byte zero, else 7.
// RL11: Memory byte multiply takes 4 or 8 plus addressing cycles.
// RL12: Accumulator word multiply upper by lower word; 3 if upper zero, else 11.
// RL13: Register word multiply; 3 cycles if register word zero, else 11.
// RL14: Memory word multiply takes 4 or 12 plus addressing cycles.
// RL15: Divides update only overflow and carry; multiplies change no flags.
// RL16: Memory extra cycles and access counts come from fetch-logic correction values.

//==========================================================================
// Cycle counts per operation: zero case, overflow case (divides only), normal case
`define UMD_DIVA_ZERO 6'h03
`define UMD_DIVA_OVF 6'h06
`define UMD_DIVA_NORM 6'h0e
`define UMD_DIVR_ZERO 6'h03
`define UMD_DIVR_OVF 6'h05
`define UMD_DIVR_NORM 6'h0d
`define UMD_DIVM_ZERO 6'h05
`define UMD_DIVM_OVF 6'h07
`define UMD_DIVM_NORM 6'h11
`define UMD_QWR_ZERO 6'h03
`define UMD_QWR_OVF 6'h05
`define UMD_QWR_NORM 6'h15
`define UMD_QWM_ZERO 6'h04
`define UMD_QWM_OVF 6'h07
`define UMD_QWM_NORM 6'h19
`define UMD_MULB_ZERO 6'h03
`define UMD_MULB_NORM 6'h07
`define UMD_MULBM_ZERO 6'h04
`define UMD_MULBM_NORM 6'h08
`define UMD_PW_ZERO 6'h03
`define UMD_PW_NORM 6'h0b
`define UMD_MULWM_ZERO 6'h04
`define UMD_MULWM_NORM 6'h0c
`endif

// *** verilog/umd_pkg.sv ***
package umd_pkg;
   // Operation selector from the sequencer
   typedef enum logic [3:0] {
      UMD_DIV_ACC = 4'h0,
      UMD_DIV_REG = 4'h1,
      UMD_DIV_MEM = 4'h2,
      UMD_QW_REG = 4'h3,
      UMD_QW_MEM = 4'h4,
      UMD_PB_ACC = 4'h5,
      UMD_PB_REG = 4'h6,
      UMD_PB_MEM = 4'h7,
      UMD_PW_ACC = 4'h8,
      UMD_PW_REG = 4'h9,
      UMD_PW_MEM = 4'ha
   } umd_op_t;

   // Outcome class that picks the cycle figure
   typedef enum logic [1:0] {
      UMD_OUT_ZERO = 2'h0,
      UMD_OUT_OVF = 2'h1,
      UMD_OUT_NORM = 2'h2
   } umd_outcome_t;

   typedef enum logic [0:0] {
      UMD_IDLE = 1'b0,
      UMD_BUSY = 1'b1
   } umd_state_t;
endpackage

// *** verilog/umd_calc_if.sv ***
`timescale 1ns/1ns
// Carries operands to the arithmetic core and its results back
interface umd_calc_if;
   logic [31:0] dividend;
   logic [15:0] divisor;
   logic is_word;
   logic [15:0] quot;
   logic [15:0] rem;
   logic div_zero;
   logic div_ovf;
   modport core (input dividend, divisor, is_word, output quot, rem, div_zero, div_ovf);
   modport user (output dividend, divisor, is_word, input quot, rem, div_zero, div_ovf);
endinterface

// *** verilog/umd_div_core.sv ***
`timescale 1ns/1ns
// Combinational unsigned divider with zero and overflow detection
module umd_div_core (
   umd_calc_if.core c
);
   logic [31:0] q_full;
   logic [31:0] r_full;
   logic [31:0] dsr;

   //==========================================================================
   // Divide
   always_comb begin
      dsr = {16'h0000, c.divisor};
      if (!c.is_word) begin
         dsr = {24'h000000, c.divisor[7:0]};
      end
      if (dsr == 32'h0) begin
         q_full = 32'h0;
         r_full = 32'h0;
      end else begin
         q_full = c.dividend / dsr;
         r_full = c.dividend % dsr;
      end
   end

   // Overflow when the quotient does not fit the destination width
   always_comb begin
      c.div_zero = (dsr == 32'h0);
      c.quot = q_full[15:0];
      c.rem = r_full[15:0];
      if (c.is_word) begin
         c.div_ovf = !c.div_zero && (q_full[31:16] != 16'h0);
      end else begin
         c.div_ovf = !c.div_zero && (q_full[31:8] != 24'h0);
      end
   end
endmodule

// *** test/umd_seq_model.sv ***
`timescale 1ns/1ns
//==========================================================================
// Sequencer stand-in
// Drives one operation at a time and measures how long the unit takes
module umd_seq_model (
   input wire logic clock_i,
   input wire logic busy_i,
   input wire logic done_i,
   output logic start_o,
   output logic [3:0] op_o,
   output logic [31:0] acc_o,
   output logic [15:0] opnd_o,
   output logic [5:0] addr_cycles_o,
   output logic [5:0] access_count_o,
   output logic flag_v_o,
   output logic flag_c_o
);
   // Idle values at time zero
   initial begin
      start_o = 1'b0;
      op_o = 4'h0;
      acc_o = 32'h0000_0000;
      opnd_o = 16'h0000;
      addr_cycles_o = 6'h00;
      access_count_o = 6'h00;
      flag_v_o = 1'b1;
      flag_c_o = 1'b1;
   end

   // Called just after an edge; n counts edges from the taking edge to done
   task automatic issue(input logic [3:0] op, input logic [31:0] acc, input logic [15:0] opnd,
         input logic [5:0] ac, input logic [5:0] cnt, input bit hold, output int n,
         output int gaps);
      n = 1;
      gaps = 0;
      start_o = 1'b1;
      op_o = op;
      acc_o = acc;
      opnd_o = opnd;
      addr_cycles_o = ac; // Fetch side supplies the correction values
      access_count_o = cnt;
      flag_v_o = ~flag_v_o;
      @(posedge clock_i);
      #1;
      // Hold keeps asking while busy, so a unit that re-takes shows up
      start_o = hold;
      // Operands go stale once taken: inverted so late sampling is caught
      op_o = ~op;
      acc_o = ~acc;
      opnd_o = ~opnd;
      addr_cycles_o = ~ac;
      access_count_o = ~cnt;
      while (done_i !== 1'b1 && n < 200) begin
         if (busy_i !== 1'b1) gaps++;
         @(posedge clock_i);
         #1;
         n++;
      end
      if (hold) begin
         start_o = 1'b0;
         @(posedge clock_i);
         #1;
      end
   endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ns
//==========================================================================
// Top-level bench
module tb_top;
   logic clock_i;
   logic rst_i;
   logic start_i;
   logic [3:0] op_i;
   logic [31:0] acc_i;
   logic [15:0] opnd_i;
   logic [5:0] addr_cycles_i;
   logic [5:0] access_count_i;
   logic flag_v_i;
   logic flag_c_i;
   logic busy_o;
   logic done_o;
   logic [31:0] acc_o;
   logic acc_we_o;
   logic [15:0] opnd_o;
   logic opnd_we_o;
   logic flag_v_o;
   logic flag_c_o;
   logic flags_we_o;
   logic [7:0] cycles_o;
   logic [7:0] accesses_o;
   int num_errors;
   int n_compared;
   logic [5:0] ac;
   logic [5:0] cnt;
   bit hold;

   umd_unit #(.ACC_W(32), .CORR_W(6)) umd_unit_inst (.clock_i(clock_i), .rst_i(rst_i),
      .start_i(start_i), .op_i(op_i), .acc_i(acc_i), .opnd_i(opnd_i),
      .addr_cycles_i(addr_cycles_i), .access_count_i(access_count_i), .flag_v_i(flag_v_i),
      .flag_c_i(flag_c_i), .busy_o(busy_o), .done_o(done_o), .acc_o(acc_o),
      .acc_we_o(acc_we_o), .opnd_o(opnd_o), .opnd_we_o(opnd_we_o), .flag_v_o(flag_v_o),
      .flag_c_o(flag_c_o), .flags_we_o(flags_we_o), .cycles_o(cycles_o),
      .accesses_o(accesses_o));

   umd_seq_model umd_seq_model_inst (.clock_i(clock_i), .busy_i(busy_o), .done_i(done_o),
      .start_o(start_i), .op_o(op_i), .acc_o(acc_i), .opnd_o(opnd_i),
      .addr_cycles_o(addr_cycles_i), .access_count_o(access_count_i), .flag_v_o(flag_v_i),
      .flag_c_o(flag_c_i));

   //=======================================================================
   // Clock, checking and ending
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   //=======================================================================
   // One operation; kind 0 multiply, 1 normal divide, 2 zero or overflow divide
   task automatic do_op(input logic [3:0] op, input logic [31:0] acc, input logic [15:0] opnd,
         input int n_exp, input int kind, input logic [31:0] acc_exp, input logic [15:0] rem_exp,
         input int b_exp);
      int n;
      int gaps;
      logic [31:0] am;
      logic [15:0] rm;
      // Byte divides touch only one byte of each result; acc divide one per half
      am = (op == 4'h0) ? 32'h00ff_00ff : (op inside {4'h1, 4'h2}) ? 32'h0000_00ff :
           (op >= 4'h8) ? 32'hffff_ffff : 32'h0000_ffff;
      rm = (op inside {4'h1, 4'h2}) ? 16'h00ff : (op inside {4'h3, 4'h4}) ? 16'hffff : 16'h0000;
      umd_seq_model_inst.issue(op, acc, opnd, ac, cnt, hold, n, gaps);
      check(n, n_exp, "done latency");
      check(cycles_o, n_exp, "cycle count");
      check(gaps, 0, "busy gap");
      check(accesses_o, b_exp, "access count");
      check(acc_we_o, kind != 2, "acc write");
      if (kind != 2) check(acc_o & am, acc_exp, "acc result");
      if (kind == 1) check(opnd_o & rm, rem_exp, "remainder");
      check(opnd_we_o, kind == 1 && rm != 16'h0000, "remainder write");
      check(flags_we_o, kind != 0, "flag write");
      if (kind != 0) check({flag_v_o, flag_c_o}, {kind == 2, 1'b0}, "v and c");
   endtask

   //=======================================================================
   // Scenarios, run back to back so each start lands in the previous done cycle
   task automatic t_div_acc;
      do_op(4'h0, 32'h1234_0364, 16'h5a5a, 14, 1, 32'h003c_002e, 16'h0000, 0);
      do_op(4'h0, 32'h0a00_0007, 16'h5a5a, 6, 2, 32'h0, 16'h0, 0);
      do_op(4'h0, 32'h0000_0500, 16'h5a5a, 3, 2, 32'h0, 16'h0, 0);
   endtask

   task automatic t_div_reg;
      do_op(4'h1, 32'h0000_03e8, 16'hff07, 13, 1, 32'h0000_008e, 16'h0006, 0);
      do_op(4'h1, 32'h0000_1000, 16'h0002, 5, 2, 32'h0, 16'h0, 0);
      do_op(4'h1, 32'h0000_1000, 16'hab00, 3, 2, 32'h0, 16'h0, 0);
      do_op(4'h3, 32'h0001_0000, 16'h0003, 21, 1, 32'h0000_5555, 16'h0001, 0);
      do_op(4'h3, 32'h0003_0000, 16'h0002, 5, 2, 32'h0, 16'h0, 0);
      do_op(4'h3, 32'h0003_0000, 16'h0000, 3, 2, 32'h0, 16'h0, 0);
   endtask

   task automatic t_div_mem;
      ac = 6'h05;
      cnt = 6'h03;
      do_op(4'h2, 32'h0000_03e8, 16'h0007, 22, 1, 32'h0000_008e, 16'h0006, 6);
      do_op(4'h2, 32'h0000_1000, 16'h0002, 12, 2, 32'h0, 16'h0, 3);
      do_op(4'h2, 32'h0000_1000, 16'h0000, 10, 2, 32'h0, 16'h0, 3);
      // Largest correction values, so no field of the sums is cut short
      ac = 6'h3f;
      cnt = 6'h3f;
      do_op(4'h4, 32'h0001_0000, 16'h0003, 88, 1, 32'h0000_5555, 16'h0001, 126);
      do_op(4'h4, 32'h0003_0000, 16'h0002, 70, 2, 32'h0, 16'h0, 63);
      do_op(4'h4, 32'h0003_0000, 16'h0000, 67, 2, 32'h0, 16'h0, 63);
   endtask

   task automatic t_mul;
      ac = 6'h05;
      cnt = 6'h03;
      do_op(4'h5, 32'h000c_000b, 16'h1111, 7, 0, 32'h0000_0084, 16'h0, 0);
      do_op(4'h5, 32'h0000_ff07, 16'h1111, 3, 0, 32'h0, 16'h0, 0);
      do_op(4'h6, 32'h0000_00ff, 16'h00ff, 7, 0, 32'h0000_fe01, 16'h0, 0);
      do_op(4'h6, 32'h0000_00ff, 16'h1200, 3, 0, 32'h0, 16'h0, 0);
      do_op(4'h7, 32'h0000_0020, 16'h0010, 13, 0, 32'h0000_0200, 16'h0, 3);
      do_op(4'h7, 32'h0000_0020, 16'hff00, 9, 0, 32'h0, 16'h0, 3);
      do_op(4'h8, 32'hffff_ffff, 16'h1111, 11, 0, 32'hfffe_0001, 16'h0, 0);
      do_op(4'h8, 32'h0000_1234, 16'h1111, 3, 0, 32'h0, 16'h0, 0);
      do_op(4'h9, 32'h0000_ffff, 16'hffff, 11, 0, 32'hfffe_0001, 16'h0, 0);
      do_op(4'h9, 32'h0000_ffff, 16'h0000, 3, 0, 32'h0, 16'h0, 0);
      do_op(4'ha, 32'h0000_ffff, 16'hffff, 17, 0, 32'hfffe_0001, 16'h0, 3);
      do_op(4'ha, 32'h0000_ffff, 16'h0000, 9, 0, 32'h0, 16'h0, 3);
   endtask

   // Start held high through the run: the unit must not restart early
   task automatic t_refuse;
      hold = 1'b1;
      do_op(4'h0, 32'h1234_0364, 16'h0000, 14, 1, 32'h003c_002e, 16'h0000, 0);
      hold = 1'b0;
   endtask

   //=======================================================================
   // Main sequence and watchdog
   initial begin
      num_errors = 0;
      n_compared = 0;
      hold = 1'b0;
      ac = 6'h2a;
      cnt = 6'h15;
      rst_i = 1'b1;
      repeat (12) @(posedge clock_i);
      #1;
      rst_i = 1'b0;
      check({busy_o, done_o, acc_we_o, flags_we_o}, 32'h0, "reset outputs");
      t_div_acc();
      t_div_reg();
      t_div_mem();
      t_mul();
      t_refuse();
      end_of_test();
   end

   // A run of under five hundred cycles; twenty times that means a hang
   initial begin
      #80000;
      num_errors++;
      end_of_test();
   end
endmodule
